// file: fsr_fan_model.sv
// fan drive model: counts the pwm high cycles the fan sees
`default_nettype none
module fsr_fan_model (
  input wire logic clock_i,
  input wire logic clr_i,
  input wire logic pwm_i,
  output logic [15:0] high_cnt_o
);
  // duty as seen by the fan is high time over a cleared window
  always_ff @(posedge clock_i) begin
    high_cnt_o <= clr_i ? 16'h0000 : high_cnt_o + {15'h0000, pwm_i};
  end
endmodule : fsr_fan_model
`default_nettype wire

// file: fsr_pkg.sv
// constants, register map and field layout of the fan speed ramp output
`default_nettype none
package fsr_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_HZ = 16;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned MANUAL_TIMEOUT_MIN = 15;
  localparam int unsigned MANUAL_TIMEOUT_TICKS = MANUAL_TIMEOUT_MIN * 60 * TICK_HZ;
  // ----------------------------------------------------------------
  // speed scale, SPD_W in bits, all other values in 0.01 % units
  // ----------------------------------------------------------------
  localparam int SPD_W = 14;
  localparam logic [13:0] FULL_SCALE = 14'h2710;   // 100.00 %
  localparam logic [13:0] INC_MIN = 14'h0001;      // 0.01 %
  localparam logic [13:0] RAMP_STEP = 14'h00C8;    // 2.00 % per ramp unit
  localparam logic [13:0] CUR_OFFSET = 14'h07D0;   // 4 mA on a 20 mA scale
  localparam logic [13:0] CUR_SPAN = 14'h1F40;     // 16 mA span
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_INCREMENT = 8'h04;
  localparam logic [7:0] OFS_MIN_SPEED = 8'h08;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h0C;
  localparam logic [7:0] OFS_EXT_SETPOINT = 8'h10;
  localparam logic [7:0] OFS_MANUAL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [13:0] RST_INCREMENT = 14'h0001;
  localparam logic [13:0] RST_MIN_SPEED = 14'h0000;
  localparam logic [13:0] RST_MAX_SPEED = 14'h2710;
  // ----------------------------------------------------------------
  // configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_ANALOG = 0;
  localparam int CFG_CURRENT = 1;
  localparam int CFG_IDLE_LO = 2;
  localparam int CFG_RELAY1 = 4;
  localparam int CFG_HF_PRE = 5;
  localparam int CFG_LF_IGN = 6;
  localparam int CFG_HF_POST = 7;
  localparam int CFG_RELAY3 = 8;
  localparam int CFG_RAMP_LO = 9;
  localparam int CFG_MAP = 14;
  localparam int CFG_RSVD = 15;
  localparam logic [1:0] IDLE_ZERO = 2'h0;
  localparam logic [1:0] IDLE_MIN = 2'h1;
  localparam logic [1:0] IDLE_MAX = 2'h2;
  localparam logic [1:0] IDLE_ERROR = 2'h3;
  // manual and status fields
  localparam int MAN_ENABLE = 16;
  localparam int ST_MANUAL = 16;
  localparam int ST_CFG_ERR = 17;
  localparam int ST_HEAT_WARN = 18;
  localparam int ST_RAMPING = 19;
endpackage : fsr_pkg
`default_nettype wire

// file: fsr_pwm.sv
// pwm generator with a duty in 0.01 % steps
`default_nettype none
module fsr_pwm #(
  parameter int unsigned DIV = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic [13:0] duty_i,
  output logic pwm_o
);
  logic [31:0] div_ff;
  logic [31:0] nxt_div;
  logic [13:0] cnt_ff;
  logic [13:0] nxt_cnt;
  logic pwm_ff;
  logic nxt_pwm;

  // ----------------------------------------------------------------
  // period counter, one period is full scale steps
  // ----------------------------------------------------------------
  always_comb begin
    nxt_div = div_ff;
    nxt_cnt = cnt_ff;
    if (div_ff >= DIV - 1) begin
      nxt_div = '0;
      nxt_cnt = (cnt_ff >= fsr_pkg::FULL_SCALE - 14'h0001) ? 14'h0000 : cnt_ff + 14'h0001;
    end else begin
      nxt_div = div_ff + 32'h0000_0001;
    end
    nxt_pwm = enable_i & (cnt_ff < duty_i);
  end

  // registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      div_ff <= 32'h0000_0000;
      cnt_ff <= 14'h0000;
      pwm_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      pwm_ff <= nxt_pwm;
    end
  end

  assign pwm_o = pwm_ff;
endmodule : fsr_pwm
`default_nettype wire

// file: fsr_top.sv
// fan speed ramp output: set-point ramp, limits, pwm/analogue drive, wishbone registers
//
// The register offsets and register access over Wishbone were left to the implementer.
`default_nettype none
module fsr_top #(
  parameter int unsigned TICK_CYCLES = fsr_pkg::TICK_CYCLES,
  parameter int unsigned MANUAL_TICKS = fsr_pkg::MANUAL_TIMEOUT_TICKS,
  parameter int unsigned PWM_DIV = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // heat control pins
  input wire logic more_heat_i,
  input wire logic less_heat_i,
  input wire logic high_fire_i,
  input wire logic low_fire_i,
  // burner sequence phases from the controller logic
  input wire logic standby_i,
  input wire logic fault_i,
  input wire logic auto_run_i,
  input wire logic op_or_wait_i,
  input wire logic pre_aeration_i,
  input wire logic ignition_i,
  input wire logic stabilise_i,
  input wire logic post_aeration_i,
  // fan drive
  output logic pwm_o,
  output logic analog_en_o,
  output logic analog_current_o,
  output logic [13:0] analog_level_o,
  output logic relay1_o,
  output logic relay3_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic more_s, less_s, high_s, low_s;
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  logic [15:0] cfg_ff, nxt_cfg;
  logic [13:0] inc_ff, nxt_inc, min_ff, nxt_min, max_ff, nxt_max;
  logic [13:0] ext_ff, nxt_ext, man_sp_ff, nxt_man_sp;
  logic manual_ff, nxt_manual;
  logic [31:0] man_cnt_ff, nxt_man_cnt;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [13:0] speed_ff, nxt_speed;
  logic [4:0] ramp_cnt_ff, nxt_ramp_cnt;
  logic cfg_err_ff, nxt_cfg_err;
  logic an_en_ff, an_cur_ff, rly1_ff, rly3_ff;
  logic [13:0] an_lvl_ff, nxt_an_lvl;
  logic wr_req, press;
  logic [4:0] ramp_val;
  logic [1:0] idle_sel;
  logic idle, heat_up, heat_dn;
  logic [13:0] base, mapped, target, idle_lvl;
  logic [27:0] map_prod, cur_prod;

  // ----------------------------------------------------------------
  // pin synchronisers, one two-stage chain per pin
  // ----------------------------------------------------------------
  logic [3:0] pins_raw, pins_s;
  assign pins_raw = {low_fire_i, high_fire_i, less_heat_i, more_heat_i};
  genvar g;
  for (g = 0; g < 4; g++) begin : g_sync
    logic s1_ff, s2_ff;
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
      end else begin
        s1_ff <= pins_raw[g];
        s2_ff <= s1_ff;
      end
    end
    assign pins_s[g] = s2_ff;
  end
  assign more_s = pins_s[0];
  assign less_s = pins_s[1];
  assign high_s = pins_s[2];
  assign low_s = pins_s[3];

  // ----------------------------------------------------------------
  // 1/16 s tick divider
  // ----------------------------------------------------------------
  always_comb begin
    nxt_tick = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + 32'h0000_0001;
    if (tick_cnt_ff >= TICK_CYCLES - 1) begin
      nxt_tick_cnt = 32'h0000_0000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave and register file
  // ----------------------------------------------------------------
  function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
    lanes = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : lanes

  function automatic logic [13:0] lim(input logic [15:0] v, input logic [13:0] lo);
    // the full 16-bit value is judged first so that bits above 13 are not lost
    if (v > {2'h0, fsr_pkg::FULL_SCALE}) lim = fsr_pkg::FULL_SCALE;
    else if (v[13:0] < lo) lim = lo;
    else lim = v[13:0];
  endfunction : lim

  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff;
  assign press = wr_req & (wb_adr_i == fsr_pkg::OFS_MANUAL) & wb_sel_i[2];

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_inc = inc_ff;
    nxt_min = min_ff;
    nxt_max = max_ff;
    nxt_ext = ext_ff;
    nxt_man_sp = man_sp_ff;
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rdat = rdat_ff;
    if (wr_req) begin
      case (wb_adr_i)
        fsr_pkg::OFS_CONFIG: begin
          nxt_cfg = lanes(cfg_ff, wb_dat_i, wb_sel_i);
          nxt_cfg[fsr_pkg::CFG_RSVD] = 1'b0;
        end
        fsr_pkg::OFS_INCREMENT: nxt_inc = lim(lanes({2'h0, inc_ff}, wb_dat_i, wb_sel_i), fsr_pkg::INC_MIN);
        fsr_pkg::OFS_MIN_SPEED: nxt_min = lim(lanes({2'h0, min_ff}, wb_dat_i, wb_sel_i), 14'h0000);
        fsr_pkg::OFS_MAX_SPEED: nxt_max = lim(lanes({2'h0, max_ff}, wb_dat_i, wb_sel_i), 14'h0000);
        fsr_pkg::OFS_EXT_SETPOINT: nxt_ext = lim(lanes({2'h0, ext_ff}, wb_dat_i, wb_sel_i), 14'h0000);
        fsr_pkg::OFS_MANUAL: nxt_man_sp = lim(lanes({2'h0, man_sp_ff}, wb_dat_i, wb_sel_i), 14'h0000);
        default: ;
      endcase
    end
    if (wb_cyc_i & wb_stb_i & ~ack_ff) begin
      case (wb_adr_i)
        fsr_pkg::OFS_CONFIG: nxt_rdat = {16'h0000, cfg_ff};
        fsr_pkg::OFS_INCREMENT: nxt_rdat = {18'h00000, inc_ff};
        fsr_pkg::OFS_MIN_SPEED: nxt_rdat = {18'h00000, min_ff};
        fsr_pkg::OFS_MAX_SPEED: nxt_rdat = {18'h00000, max_ff};
        fsr_pkg::OFS_EXT_SETPOINT: nxt_rdat = {18'h00000, ext_ff};
        fsr_pkg::OFS_MANUAL: nxt_rdat = {15'h0000, manual_ff, 2'h0, man_sp_ff};
        fsr_pkg::OFS_STATUS: nxt_rdat = {12'h000, (speed_ff != target), more_s & less_s, cfg_err_ff,
                                         manual_ff, 2'h0, speed_ff};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_ff <= fsr_pkg::RST_CONFIG;
      inc_ff <= fsr_pkg::RST_INCREMENT;
      min_ff <= fsr_pkg::RST_MIN_SPEED;
      max_ff <= fsr_pkg::RST_MAX_SPEED;
      ext_ff <= 14'h0000;
      man_sp_ff <= 14'h0000;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      cfg_ff <= nxt_cfg;
      inc_ff <= nxt_inc;
      min_ff <= nxt_min;
      max_ff <= nxt_max;
      ext_ff <= nxt_ext;
      man_sp_ff <= nxt_man_sp;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // ----------------------------------------------------------------
  // manual set-point mode with button timeout
  // ----------------------------------------------------------------
  always_comb begin
    nxt_manual = manual_ff;
    nxt_man_cnt = man_cnt_ff;
    if (manual_ff & tick_ff) begin
      if (man_cnt_ff >= MANUAL_TICKS - 1) begin
        nxt_manual = 1'b0;
        nxt_man_cnt = 32'h0000_0000;
      end else begin
        nxt_man_cnt = man_cnt_ff + 32'h0000_0001;
      end
    end
    if (!op_or_wait_i) begin
      nxt_manual = 1'b0;
    end
    // a press wins over an expiry in the same cycle
    if (press) begin
      nxt_manual = wb_dat_i[fsr_pkg::MAN_ENABLE] & op_or_wait_i;
      nxt_man_cnt = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      manual_ff <= 1'b0;
      man_cnt_ff <= 32'h0000_0000;
    end else begin
      manual_ff <= nxt_manual;
      man_cnt_ff <= nxt_man_cnt;
    end
  end

  // ----------------------------------------------------------------
  // target set-point: source, span mapping, fire control, limits
  // ----------------------------------------------------------------
  assign ramp_val = cfg_ff[fsr_pkg::CFG_RAMP_LO +: 5];
  assign idle_sel = cfg_ff[fsr_pkg::CFG_IDLE_LO +: 2];
  assign idle = standby_i | fault_i;
  assign heat_up = more_s & ~less_s & ~manual_ff;
  assign heat_dn = less_s & ~more_s & ~manual_ff;
  assign map_prod = 28'(base) * 28'(max_ff - min_ff);
  assign cur_prod = 28'(speed_ff) * 28'(fsr_pkg::CUR_SPAN);

  always_comb begin
    base = manual_ff ? man_sp_ff : ext_ff;
    mapped = base;
    if (cfg_ff[fsr_pkg::CFG_MAP] && max_ff > min_ff) begin
      mapped = min_ff + 14'(map_prod / 28'(fsr_pkg::FULL_SCALE));
    end
    target = mapped;
    if (cfg_ff[fsr_pkg::CFG_HF_PRE] & pre_aeration_i & high_s) begin
      target = max_ff;
    end
    if (cfg_ff[fsr_pkg::CFG_HF_POST] & post_aeration_i & high_s) begin
      target = max_ff;
    end
    if (cfg_ff[fsr_pkg::CFG_LF_IGN] & (ignition_i | stabilise_i) & low_s) begin
      target = min_ff;
    end
    if (target > max_ff) target = max_ff;
    if (target < min_ff) target = min_ff;
    case (idle_sel)
      fsr_pkg::IDLE_MIN: idle_lvl = min_ff;
      fsr_pkg::IDLE_MAX: idle_lvl = max_ff;
      default: idle_lvl = 14'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // speed ramp, stepped once per tick
  // ----------------------------------------------------------------
  always_comb begin
    nxt_speed = speed_ff;
    nxt_ramp_cnt = ramp_cnt_ff;
    nxt_cfg_err = (idle_sel == fsr_pkg::IDLE_ERROR);
    if (tick_ff) begin
      if (nxt_cfg_err) begin
        nxt_speed = 14'h0000;
        nxt_ramp_cnt = 5'h00;
      end else if (idle) begin
        nxt_speed = idle_lvl;
        nxt_ramp_cnt = 5'h00;
      end else if (heat_up) begin
        nxt_speed = (15'(speed_ff) + 15'(inc_ff) > 15'(max_ff)) ? max_ff : speed_ff + inc_ff;
        nxt_ramp_cnt = 5'h00;
      end else if (heat_dn) begin
        // widened sum so that min plus increment cannot wrap past 14 bits
        nxt_speed = (15'(speed_ff) < 15'(min_ff) + 15'(inc_ff)) ? min_ff : speed_ff - inc_ff;
        nxt_ramp_cnt = 5'h00;
      end else if (ramp_val == 5'h00) begin
        nxt_speed = target;
        nxt_ramp_cnt = 5'h00;
      end else if (speed_ff == target) begin
        nxt_ramp_cnt = 5'h00;
      end else if (ramp_cnt_ff >= ramp_val - 5'h01) begin
        nxt_ramp_cnt = 5'h00;
        // 2 % every ramp_val ticks gives 3.125 s per unit over full scale
        if (speed_ff < target) begin
          nxt_speed = (target - speed_ff > fsr_pkg::RAMP_STEP) ? speed_ff + fsr_pkg::RAMP_STEP : target;
        end else begin
          nxt_speed = (speed_ff - target > fsr_pkg::RAMP_STEP) ? speed_ff - fsr_pkg::RAMP_STEP : target;
        end
      end else begin
        nxt_ramp_cnt = ramp_cnt_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      speed_ff <= 14'h0000;
      ramp_cnt_ff <= 5'h00;
      cfg_err_ff <= 1'b0;
    end else begin
      speed_ff <= nxt_speed;
      ramp_cnt_ff <= nxt_ramp_cnt;
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  // ----------------------------------------------------------------
  // output drive: analogue level and relays
  // ----------------------------------------------------------------
  always_comb begin
    nxt_an_lvl = 14'h0000;
    if (cfg_ff[fsr_pkg::CFG_ANALOG]) begin
      if (cfg_ff[fsr_pkg::CFG_CURRENT]) begin
        nxt_an_lvl = fsr_pkg::CUR_OFFSET + 14'(cur_prod / 28'(fsr_pkg::FULL_SCALE));
      end else begin
        nxt_an_lvl = speed_ff;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      an_en_ff <= 1'b0;
      an_cur_ff <= 1'b0;
      an_lvl_ff <= 14'h0000;
      rly1_ff <= 1'b0;
      rly3_ff <= 1'b0;
    end else begin
      an_en_ff <= cfg_ff[fsr_pkg::CFG_ANALOG];
      an_cur_ff <= cfg_ff[fsr_pkg::CFG_ANALOG] & cfg_ff[fsr_pkg::CFG_CURRENT];
      an_lvl_ff <= nxt_an_lvl;
      rly1_ff <= cfg_ff[fsr_pkg::CFG_RELAY1] & auto_run_i & ~fault_i;
      rly3_ff <= cfg_ff[fsr_pkg::CFG_RELAY3] & high_s & ~fault_i;
    end
  end

  // pwm runs only while the pwm output type is selected
  fsr_pwm #(
    .DIV(PWM_DIV)
  ) u_pwm (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(~cfg_ff[fsr_pkg::CFG_ANALOG]),
    .duty_i(speed_ff),
    .pwm_o(pwm_o)
  );

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign analog_en_o = an_en_ff;
  assign analog_current_o = an_cur_ff;
  assign analog_level_o = an_lvl_ff;
  assign relay1_o = rly1_ff;
  assign relay3_o = rly3_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_normal_tick;
    tick_ff && !idle && !cfg_err_ff && idle_sel != fsr_pkg::IDLE_ERROR && !heat_up && !heat_dn;
  endsequence

  sequence s_expire;
    manual_ff && tick_ff && man_cnt_ff == MANUAL_TICKS - 1 && !press && op_or_wait_i;
  endsequence

  AST_SPEED_ONLY_ON_TICK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !tick_ff |=> $stable(speed_ff)) else $error("speed changed off the tick");
  AST_TICK_SPACING: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tick_ff |=> !tick_ff) else $error("tick pulses back to back");
  AST_INC_RANGE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    inc_ff >= fsr_pkg::INC_MIN && inc_ff <= fsr_pkg::FULL_SCALE) else $error("increment out of range");
  AST_CLAMP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_normal_tick and (min_ff <= max_ff) |=> speed_ff >= $past(min_ff) && speed_ff <= $past(max_ff))
    else $error("speed outside limits");
  AST_CFG_ERROR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    idle_sel == fsr_pkg::IDLE_ERROR && tick_ff |=> cfg_err_ff && speed_ff == 14'h0000)
    else $error("invalid idle setting not flagged");
  AST_RELAY1: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cfg_ff[fsr_pkg::CFG_RELAY1] |=> !relay1_o) else $error("relay 1 closed while disabled");
  AST_JUMP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_normal_tick and (ramp_val == 5'h00) |=> speed_ff == $past(target)) else $error("zero ramp did not jump");
  AST_RAMP_STEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_normal_tick and (ramp_val != 5'h00) |=> speed_ff - $past(speed_ff) <= fsr_pkg::RAMP_STEP ||
    $past(speed_ff) - speed_ff <= fsr_pkg::RAMP_STEP) else $error("ramp step too large");
  AST_RSVD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cfg_ff[fsr_pkg::CFG_RSVD]) else $error("reserved bit stored");
  AST_MANUAL_TIMEOUT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_expire |=> !manual_ff) else $error("manual mode did not time out");
  AST_ACK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wb_cyc_i && wb_stb_i && !ack_ff |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer not one cycle");
endmodule : fsr_top
`default_nettype wire

// file: fsr_top_tb_top.sv
// self-checking bench of the fan speed ramp output
`default_nettype none
module fsr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 20;
  logic clock_i = 0, rst_n_i = 0, req = 0, we = 0, mh = 0, hf = 0, sb = 0, flt = 0, ar = 0, ow = 0, pre = 0, clr = 0;
  logic lh = 0, lf = 0, ign = 0, post = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic ack, pwm, aen, acur, r1, r3;
  logic [13:0] alvl;
  logic [15:0] hcnt;
  int errors = 0, compares = 0;
  // 125 MHz clock
  always #4 clock_i = ~clock_i;
  // design and fan model
  fsr_top #(.TICK_CYCLES(TK), .MANUAL_TICKS(5), .PWM_DIV(1)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .more_heat_i(mh), .less_heat_i(lh), .high_fire_i(hf), .low_fire_i(lf),
    .standby_i(sb), .fault_i(flt), .auto_run_i(ar), .op_or_wait_i(ow), .pre_aeration_i(pre), .ignition_i(ign),
    .stabilise_i(1'b0), .post_aeration_i(post), .pwm_o(pwm), .analog_en_o(aen), .analog_current_o(acur),
    .analog_level_o(alvl), .relay1_o(r1), .relay3_o(r3));
  fsr_fan_model fan_u (.clock_i(clock_i), .clr_i(clr), .pwm_i(pwm), .high_cnt_o(hcnt));
  task automatic report_and_stop();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) begin
      errors++;
      report_and_stop();
    end
    req <= 1'b0;
    @(posedge clock_i);
  endtask : wb
  task automatic cw(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, (a == 8'h14) ? 4'h7 : 4'h3);
  endtask : cw
  task automatic tk(input int n);
    repeat (n * TK) @(posedge clock_i);
  endtask : tk
  task automatic sp(input logic [13:0] e);
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk("speed", {18'h0, e}, {18'h0, q[13:0]});
  endtask : sp
  task automatic pw(input logic [15:0] e);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    repeat (10001) @(posedge clock_i);
    chk("pwm high", {16'h0, e}, {16'h0, hcnt});
  endtask : pw
  task automatic t_regs();
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("increment", 32'h1, q);
    cw(8'h04, 32'h4000);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("increment high", 32'h2710, q);
    cw(8'h04, 32'h0);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("increment low", 32'h1, q);
    wb(1'b0, 8'h0C, 32'h0, 4'hF);
    chk("max", 32'h2710, q);
    cw(8'h00, 32'h0000_7FFF);
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk("config", 32'h7FFF, q);
    wb(1'b0, 8'hFC, 32'h0, 4'hF);
    chk("unmapped", 32'h0, q);
    cw(8'h00, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_out();
    cw(8'h10, 32'h0BB8);
    tk(2);
    sp(14'h0BB8);
    pw(16'h0BB8);
    chk("level pwm", 32'h0, {18'h0, alvl});
    cw(8'h00, 32'h1);
    tk(1);
    chk("volt", 32'h10BB8, {15'h0, aen, 2'h0, alvl});
    pw(16'h0000);
    cw(8'h00, 32'h3);
    tk(1);
    chk("current", 32'h11130, {15'h0, acur, 2'h0, alvl});
    $display("outputs done");
  endtask : t_out
  task automatic t_ramp();
    cw(8'h00, 32'h0200);
    cw(8'h10, 32'h0FA0);
    tk(2);
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk("ramp", 32'h1, {31'h0, q[13:0] > 14'h0BB8 && q[13:0] < 14'h0FA0 &&
      (q[13:0] - 14'h0BB8) % 14'h00C8 == 0});
    chk("ramping", 32'h80000, q & 32'h80000);
    tk(6);
    sp(14'h0FA0);
    cw(8'h00, 32'h0400);
    cw(8'h10, 32'h0BB8);
    tk(4);
    sp(14'h0E10);
    tk(8);
    sp(14'h0BB8);
    $display("ramp done");
  endtask : t_ramp
  task automatic t_clamp();
    cw(8'h00, 32'h0);
    cw(8'h08, 32'h07D0);
    cw(8'h0C, 32'h1F40);
    cw(8'h10, 32'h2328);
    tk(2);
    sp(14'h1F40);
    cw(8'h10, 32'h01F4);
    tk(2);
    sp(14'h07D0);
    cw(8'h00, 32'h4000);
    cw(8'h10, 32'h09C4);
    tk(2);
    sp(14'h0DAC);
    $display("clamp done");
  endtask : t_clamp
  task automatic t_idle();
    logic [13:0] ex [3] = '{14'h0000, 14'h07D0, 14'h1F40};
    sb <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cw(8'h00, 32'(i) << 2);
      tk(2);
      sp(ex[i]);
    end
    cw(8'h00, 32'h000C);
    sb <= 1'b0;
    tk(2);
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk("cfg error", 32'h20000, q & 32'h23FFF);
    $display("idle done");
  endtask : t_idle
  task automatic t_heat();
    cw(8'h00, 32'h0);
    cw(8'h10, 32'h1388);
    cw(8'h04, 32'h0064);
    tk(2);
    mh <= 1'b1;
    tk(3);
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk("heat", 32'h1, {31'h0, q[13:0] > 14'h1388 && (q[13:0] - 14'h1388) % 14'h0064 == 0});
    tk(40);
    sp(14'h1F40);
    mh <= 1'b0;
    lh <= 1'b1;
    tk(62);
    sp(14'h07D0);
    mh <= 1'b1;
    tk(1);
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk("both heat", 32'h40000, q & 32'h40000);
    mh <= 1'b0;
    lh <= 1'b0;
    $display("heat done");
  endtask : t_heat
  task automatic t_relay();
    cw(8'h00, 32'h0110);
    ar <= 1'b1;
    hf <= 1'b1;
    tk(1);
    chk("relays", 32'h3, {30'h0, r1, r3});
    flt <= 1'b1;
    tk(1);
    chk("relays fault", 32'h0, {30'h0, r1, r3});
    sp(14'h0000);
    flt <= 1'b0;
    cw(8'h00, 32'h0);
    tk(1);
    chk("relays open", 32'h0, {30'h0, r1, r3});
    cw(8'h00, 32'h0020);
    pre <= 1'b1;
    tk(2);
    sp(14'h1F40);
    pre <= 1'b0;
    cw(8'h00, 32'h0040);
    ign <= 1'b1;
    lf <= 1'b1;
    tk(2);
    sp(14'h07D0);
    cw(8'h00, 32'h0080);
    post <= 1'b1;
    tk(2);
    sp(14'h1F40);
    ign <= 1'b0;
    lf <= 1'b0;
    post <= 1'b0;
    hf <= 1'b0;
    $display("relay done");
  endtask : t_relay
  task automatic t_manual();
    cw(8'h00, 32'h0);
    ow <= 1'b1;
    cw(8'h14, 32'h0001_0BB8);
    tk(2);
    sp(14'h0BB8);
    chk("manual on", 32'h10000, q & 32'h10000);
    tk(8);
    sp(14'h1388);
    chk("manual off", 32'h0, q & 32'h10000);
    $display("manual done");
  endtask : t_manual
  // main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_out();
    t_ramp();
    t_clamp();
    t_idle();
    t_heat();
    t_relay();
    t_manual();
    report_and_stop();
  end
endmodule : fsr_top_tb_top
`default_nettype wire
